// File: pkg/swsb_cfg.svh
// constants of the single-wire sensor bus slave
`ifndef SWSB_CFG_SVH
`define SWSB_CFG_SVH

// =========================================
// wire addressing
`define DEVNUM_BCAST 3'h0
`define DEVNUM_STRAP_LO 3'h1
`define DEVNUM_STRAP_HI 3'h2
`define REG_DEVNUM 6'h00
`define REG_STATUS 6'h04
`define REG_CONTROL 6'h05

// =========================================
// field positions and reset values
`define ST_BER_BIT 7
`define CT_EN1_BIT 4
`define CT_EN2_BIT 5
`define CTRL_RESET 8'h00

// =========================================
// bit counts (last index of each field, data bits of the attention hold-off)
`define DEV_LAST 4'h2
`define ADDR_LAST 4'h5
`define DATA_LAST8 4'h7
`define DATA_LAST16 4'hF
`define ATTN_HOLDOFF 4'hE

// =========================================
// local software port offsets
`define SW_STAT 4'h0
`define SW_EVT 4'h4

`endif

// File: pkg/swsb_pkg.sv
// types of the single-wire sensor bus slave
package swsb_pkg;

    // decoded bit signal kinds from the pulse-width layer
    typedef enum logic [2:0] {
        BK_D0,
        BK_D1,
        BK_START,
        BK_ATTN,
        BK_RESET
    } bit_kind_t;

    typedef struct packed {
        logic valid;
        bit_kind_t kind;
    } bit_evt_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [3:0] addr;
        logic [7:0] wdata;
    } sw_req_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [15:0] wdata;
    } app_req_t;

    typedef enum logic [3:0] {
        S_IDLE,
        S_DEV,
        S_ADDR,
        S_RW,
        S_DATA,
        S_PAR,
        S_ACK,
        S_SKIP,
        S_DONE
    } state_t;

endpackage : swsb_pkg

// File: src/single_wire_sensor_bus_slave.sv
// transaction layer of a single-wire sensor bus slave
`timescale 1ns/1ps
`default_nettype none
`include "swsb_cfg.svh"
module single_wire_sensor_bus_slave (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic addr_strap,
    input wire swsb_pkg::bit_evt_t bit_evt,
    input wire logic conflict,
    input wire logic bus_idle,
    output logic tx_one,
    output logic attn_go,
    output swsb_pkg::app_req_t app_req,
    input wire logic [15:0] app_rdata,
    input wire logic app_wide,
    input wire swsb_pkg::sw_req_t sw_req,
    output logic [7:0] sw_rdata
);

    // =========================================
    // decoded events
    swsb_pkg::state_t state_q;
    logic [3:0] cnt_q;
    logic [2:0] dev_q;
    logic [5:0] addr_q;
    logic rw_q;
    logic wide_q;
    logic local_q;
    logic ld_q;
    logic [15:0] sh_q;
    logic par_q;
    logic par_ok_q;
    logic err_q;
    logic ber_q;
    logic [1:0] sf_q;
    logic [7:0] ctrl_q;
    logic [2:0] devnum_q;
    logic strap1_q;
    logic strap2_q;
    logic strap3_q;
    logic strap_ld_q;
    logic [3:0] hold_q;
    logic atn_block_q;
    logic func_pend_q;
    logic ber_pend_q;
    logic attn_go_q;
    logic tx_one_q;
    logic ev_data;
    logic ev_start;
    logic ev_reset;
    logic ev_attn;
    logic b;
    logic hit;
    logic done_ack;
    logic ok;
    logic nok;
    logic armed;
    logic in_xfer;
    logic is_loc;
    logic [3:0] data_last;
    logic [7:0] loc_rdata;
    logic [1:0] func_evt;

    assign ev_data = bit_evt.valid &&
        (bit_evt.kind == swsb_pkg::BK_D0 || bit_evt.kind == swsb_pkg::BK_D1);
    assign ev_start = bit_evt.valid && bit_evt.kind == swsb_pkg::BK_START;
    assign ev_reset = bit_evt.valid && bit_evt.kind == swsb_pkg::BK_RESET;
    assign ev_attn = bit_evt.valid && bit_evt.kind == swsb_pkg::BK_ATTN;
    assign b = bit_evt.kind == swsb_pkg::BK_D1;
    assign data_last = wide_q ? `DATA_LAST16 : `DATA_LAST8;
    assign in_xfer = state_q != swsb_pkg::S_IDLE &&
        state_q != swsb_pkg::S_SKIP && state_q != swsb_pkg::S_DONE;
    // registers held inside the slave, never forwarded
    assign is_loc = addr_q == `REG_DEVNUM || addr_q == `REG_STATUS ||
        addr_q == `REG_CONTROL;
    assign hit = (dev_q == devnum_q && devnum_q != `DEVNUM_BCAST) ||
        (dev_q == `DEVNUM_BCAST && !b && addr_q == `REG_CONTROL);
    assign done_ack = ev_data && state_q == swsb_pkg::S_ACK;
    assign ok = done_ack && b && !err_q;
    assign nok = done_ack && !ok;
    assign armed = hold_q == `ATTN_HOLDOFF;

    always_comb begin
        unique case (addr_q)
            `REG_DEVNUM: loc_rdata = {5'h00, devnum_q};
            `REG_STATUS: loc_rdata = {ber_q, 5'h00, sf_q};
            `REG_CONTROL: loc_rdata = ctrl_q;
            default: loc_rdata = 8'h00;
        endcase
    end

    // =========================================
    // transaction sequencer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= swsb_pkg::S_IDLE;
            cnt_q <= 4'h0;
            dev_q <= 3'h0;
            addr_q <= 6'h00;
            rw_q <= 1'b0;
            wide_q <= 1'b0;
            local_q <= 1'b0;
        end else if (ev_reset) begin
            state_q <= swsb_pkg::S_IDLE;
            cnt_q <= 4'h0;
        end else if (ev_start) begin
            state_q <= swsb_pkg::S_DEV;
            cnt_q <= 4'h0;
        end else if (ev_data) begin
            unique case (state_q)
                swsb_pkg::S_DEV: begin
                    dev_q <= {dev_q[1:0], b};
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == `DEV_LAST) begin
                        state_q <= swsb_pkg::S_ADDR;
                        cnt_q <= 4'h0;
                    end
                end
                swsb_pkg::S_ADDR: begin
                    addr_q <= {addr_q[4:0], b};
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == `ADDR_LAST) begin
                        state_q <= swsb_pkg::S_RW;
                    end
                end
                swsb_pkg::S_RW: begin
                    rw_q <= b;
                    cnt_q <= 4'h0;
                    local_q <= is_loc;
                    wide_q <= !is_loc && app_wide;
                    state_q <= hit ? swsb_pkg::S_DATA : swsb_pkg::S_SKIP;
                end
                swsb_pkg::S_DATA: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == data_last) begin
                        state_q <= swsb_pkg::S_PAR;
                    end
                end
                swsb_pkg::S_PAR: state_q <= swsb_pkg::S_ACK;
                swsb_pkg::S_ACK: state_q <= swsb_pkg::S_DONE;
                default: state_q <= state_q;
            endcase
        end
    end

    // =========================================
    // data shifter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sh_q <= 16'h0000;
            ld_q <= 1'b0;
        end else begin
            ld_q <= ev_data && state_q == swsb_pkg::S_RW && b && hit;
            if (ld_q) begin
                if (local_q) begin
                    sh_q <= {loc_rdata, 8'h00};
                end else if (wide_q) begin
                    sh_q <= app_rdata;
                end else begin
                    sh_q <= {app_rdata[7:0], 8'h00};
                end
            end else if (ev_data && state_q == swsb_pkg::S_DATA) begin
                sh_q <= rw_q ? {sh_q[14:0], 1'b0} : {sh_q[14:0], b};
            end
        end
    end

    // =========================================
    // parity and conflict tracking
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            par_q <= 1'b0;
            par_ok_q <= 1'b0;
            err_q <= 1'b0;
        end else if (ev_start || ev_reset) begin
            par_q <= 1'b0;
            par_ok_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            if (conflict && in_xfer) begin
                err_q <= 1'b1;
            end
            if (ev_data && (state_q == swsb_pkg::S_DEV ||
                    state_q == swsb_pkg::S_ADDR ||
                    state_q == swsb_pkg::S_RW ||
                    state_q == swsb_pkg::S_DATA)) begin
                par_q <= par_q ^ b;
            end
            if (ev_data && state_q == swsb_pkg::S_PAR) begin
                par_ok_q <= rw_q || (par_q == b);
            end
        end
    end

    // =========================================
    // line drive for data, parity and acknowledge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_one_q <= 1'b0;
        end else begin
            unique case (state_q)
                swsb_pkg::S_DATA: tx_one_q <= rw_q && sh_q[15];
                swsb_pkg::S_PAR: tx_one_q <= rw_q && par_q;
                swsb_pkg::S_ACK: tx_one_q <= !rw_q && par_ok_q && !err_q;
                default: tx_one_q <= 1'b0;
            endcase
        end
    end
    assign tx_one = tx_one_q;

    // =========================================
    // device registers, untouched by bus reset
    assign func_evt = (sw_req.we && sw_req.addr == `SW_EVT) ?
        sw_req.wdata[1:0] : 2'h0;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= `CTRL_RESET;
        end else if (ok && !rw_q && local_q && addr_q == `REG_CONTROL) begin
            ctrl_q <= sh_q[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ber_q <= 1'b0;
            sf_q <= 2'h0;
        end else begin
            // status read clears, new events win
            if (ok && rw_q && addr_q == `REG_STATUS) begin
                ber_q <= nok;
                sf_q <= func_evt;
            end else begin
                ber_q <= ber_q | nok;
                sf_q <= sf_q | func_evt;
            end
            if (nok) begin
                ber_q <= 1'b1;
            end
        end
    end

    // =========================================
    // forwarded register access
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            app_req <= '0;
        end else begin
            app_req.addr <= addr_q;
            app_req.rd <= ev_data && state_q == swsb_pkg::S_RW && b && hit &&
                !is_loc;
            // data used only after good parity and ack
            app_req.wr <= ok && !rw_q && !local_q;
            app_req.wdata <= wide_q ? sh_q : {8'h00, sh_q[7:0]};
        end
    end

    // =========================================
    // strap sampling
    always_ff @(posedge clk_sys) begin
        strap1_q <= addr_strap;
        strap2_q <= strap1_q;
        strap3_q <= strap2_q;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strap_ld_q <= 1'b1;
            devnum_q <= `DEVNUM_BCAST;
        end else if (strap_ld_q && strap2_q == strap3_q) begin
            strap_ld_q <= 1'b0;
            devnum_q <= strap3_q ? `DEVNUM_STRAP_HI : `DEVNUM_STRAP_LO;
        end
    end

    // =========================================
    // attention request generation
    always_ff @(posedge clk_sys) begin
        if (rst || ev_reset) begin
            hold_q <= 4'h0;
        end else if (ev_data && !armed) begin
            hold_q <= hold_q + 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || ev_reset) begin
            atn_block_q <= 1'b0;
        end else if (ev_attn || attn_go_q) begin
            atn_block_q <= 1'b1;
        end else if (ok && rw_q && addr_q == `REG_STATUS) begin
            atn_block_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            func_pend_q <= 1'b0;
            ber_pend_q <= 1'b0;
            attn_go_q <= 1'b0;
        end else if (ev_reset) begin
            func_pend_q <= 1'b0;
            ber_pend_q <= 1'b0;
            attn_go_q <= 1'b0;
        end else begin
            attn_go_q <= 1'b0;
            if ((func_evt[0] && ctrl_q[`CT_EN1_BIT]) ||
                    (func_evt[1] && ctrl_q[`CT_EN2_BIT])) begin
                func_pend_q <= 1'b1;
            end else if (func_pend_q && bus_idle && armed &&
                    !bit_evt.valid) begin
                // first idle decides the function attention
                func_pend_q <= 1'b0;
                if (!atn_block_q) begin
                    attn_go_q <= 1'b1;
                end
            end
            if (nok) begin
                ber_pend_q <= 1'b1;
            end else if (ber_pend_q && bus_idle && armed &&
                    !bit_evt.valid) begin
                ber_pend_q <= 1'b0;
                attn_go_q <= 1'b1;
            end
        end
    end
    assign attn_go = attn_go_q;

    // =========================================
    // software port
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sw_rdata <= 8'h00;
        end else if (sw_req.re) begin
            unique case (sw_req.addr)
                `SW_STAT: sw_rdata <= {ber_q, ber_pend_q, atn_block_q,
                    armed, strap_ld_q, devnum_q};
                `SW_EVT: sw_rdata <= {6'h00, sf_q};
                default: sw_rdata <= 8'h00;
            endcase
        end else begin
            sw_rdata <= 8'h00;
        end
    end

    // =========================================
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_rst_keeps_ctrl;
        ev_reset |=> $stable(ctrl_q) && state_q == swsb_pkg::S_IDLE;
    endproperty
    a_rst_keeps_ctrl: assert property (p_rst_keeps_ctrl)
        else $error("bus reset changed control register");

    property p_bcast_read_skip;
        ev_data && state_q == swsb_pkg::S_RW && b &&
            dev_q == `DEVNUM_BCAST |=> state_q == swsb_pkg::S_SKIP;
    endproperty
    a_bcast_read_skip: assert property (p_bcast_read_skip)
        else $error("broadcast read was answered");

    property p_nack_sets_ber;
        nok |=> ber_q && ber_pend_q && state_q == swsb_pkg::S_DONE;
    endproperty
    a_nack_sets_ber: assert property (p_nack_sets_ber)
        else $error("nack did not set bus error");

    property p_abort_silent;
        ev_start && in_xfer |=> state_q == swsb_pkg::S_DEV &&
            !$rose(ber_pend_q) && !err_q;
    endproperty
    a_abort_silent: assert property (p_abort_silent)
        else $error("abort raised an error");

    property p_hold_off;
        attn_go |-> hold_q == `ATTN_HOLDOFF;
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("attention inside reset hold-off");

    property p_func_block;
        atn_block_q && !ber_pend_q |=> !attn_go;
    endproperty
    a_func_block: assert property (p_func_block)
        else $error("function attention while suppressed");

    property p_write_ack;
        state_q == swsb_pkg::S_ACK && !rw_q |=>
            tx_one == ($past(par_ok_q) && !$past(err_q));
    endproperty
    a_write_ack: assert property (p_write_ack)
        else $error("wrong write acknowledge drive");

    property p_read_par;
        state_q == swsb_pkg::S_PAR && rw_q |=> tx_one == $past(par_q);
    endproperty
    a_read_par: assert property (p_read_par)
        else $error("wrong read parity drive");

    property p_ber_attn;
        ber_pend_q && bus_idle && armed && !bit_evt.valid |=> attn_go;
    endproperty
    a_ber_attn: assert property (p_ber_attn)
        else $error("bus error attention not sent");

endmodule : single_wire_sensor_bus_slave
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench of the sensor bus slave
`timescale 1ns/1ps
`default_nettype none
`include "swsb_cfg.svh"
module tb_top;
    logic clk_sys;
    logic rst;
    logic addr_strap;
    swsb_pkg::bit_evt_t bit_evt;
    logic conflict;
    logic bus_idle;
    logic tx_one;
    logic attn_go;
    swsb_pkg::app_req_t app_req;
    logic [15:0] app_rdata;
    logic app_wide;
    swsb_pkg::sw_req_t sw_req;
    logic [7:0] sw_rdata;
    logic [2:0] dv;
    logic [15:0] rnd;
    logic [15:0] attn_cnt = 16'h0000;
    logic [15:0] attn_exp = 16'h0000;
    logic re_d = 1'b0;
    logic [7:0] sw_e;
    logic [7:0] sw_m;
    logic [7:0] sw_exp[$];
    logic [7:0] sw_msk[$];
    swsb_pkg::app_req_t app_exp[$];
    swsb_pkg::app_req_t a_e;
    int err_total = 0;
    int n_checks = 0;
    int i;

    single_wire_sensor_bus_slave dut_u (.clk_sys(clk_sys), .rst(rst),
        .addr_strap(addr_strap), .bit_evt(bit_evt), .conflict(conflict),
        .bus_idle(bus_idle), .tx_one(tx_one), .attn_go(attn_go),
        .app_req(app_req), .app_rdata(app_rdata), .app_wide(app_wide),
        .sw_req(sw_req), .sw_rdata(sw_rdata));
    wire_master_model mdl_u (.clk_sys(clk_sys), .tx_one(tx_one),
        .bit_evt(bit_evt), .bus_idle(bus_idle), .conflict(conflict));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // =========================================
    // checking
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    always @(posedge clk_sys) re_d <= sw_req.re;

    always @(negedge clk_sys) begin
        if (re_d === 1'b1) begin
            sw_e = sw_exp.pop_front();
            sw_m = sw_msk.pop_front();
            chk("sw_rdata", {8'h00, sw_e & sw_m}, {8'h00, sw_rdata & sw_m});
        end
        if (app_req.rd === 1'b1 || app_req.wr === 1'b1) begin
            if (app_exp.size() == 0) begin
                chk("app_req unexpected", 16'h0000, 16'h0001);
            end else begin
                a_e = app_exp.pop_front();
                chk("app_req", {a_e.rd, a_e.wr, a_e.addr,
                    a_e.wr ? a_e.wdata[7:0] : 8'h00},
                    {app_req.rd, app_req.wr, app_req.addr,
                    a_e.wr ? app_req.wdata[7:0] : 8'h00});
                if (a_e.wr) begin
                    chk("app wdata", a_e.wdata, app_req.wdata);
                end
            end
        end
        if (attn_go === 1'b1) attn_cnt = attn_cnt + 16'h0001;
    end

    // =========================================
    // drivers
    task automatic sw_acc(input logic we, input logic [3:0] a,
                          input logic [7:0] d, input logic [7:0] m);
        @(posedge clk_sys);
        sw_req <= '{we: we, re: !we, addr: a, wdata: we ? d : 8'h00};
        if (!we) begin
            sw_exp.push_back(d);
            sw_msk.push_back(m);
        end
        @(posedge clk_sys);
        sw_req <= '0;
    endtask : sw_acc

    function automatic swsb_pkg::bit_kind_t kd(input logic v);
        return v ? swsb_pkg::BK_D1 : swsb_pkg::BK_D0;
    endfunction : kd

    function automatic logic par_of(input logic [9:0] h,
                                    input logic [15:0] d, input int nb);
        return ^h ^ ^(d & (16'hFFFF >> (16 - nb)));
    endfunction : par_of

    task automatic xact(input logic [2:0] dn, input logic [5:0] ra,
        input logic rw, input logic [15:0] wd, input int nb,
        input logic bad, input logic cf, output logic [15:0] rd,
        output logic pb);
        logic [9:0] h;
        logic b;
        int k;
        h = {dn, ra, rw};
        rd = 16'h0000;
        mdl_u.send_bit(swsb_pkg::BK_START);
        for (k = 9; k >= 0; k--) mdl_u.send_bit(kd(h[k]));
        if (rw) begin
            for (k = 0; k < nb; k++) begin
                mdl_u.slot(b);
                rd = {rd[14:0], b};
            end
            mdl_u.slot(pb);
            mdl_u.send_bit(kd(pb === par_of(h, rd, nb)));
        end else begin
            for (k = nb - 1; k >= 0; k--) mdl_u.send_bit(kd(wd[k]));
            if (cf) mdl_u.flag_conflict();
            mdl_u.send_bit(kd(par_of(h, wd, nb) ^ bad));
            mdl_u.slot(pb);
        end
    endtask : xact

    task automatic rd_chk(input logic [2:0] dn, input logic [5:0] ra,
                          input int nb, input logic [15:0] e);
        logic [15:0] r;
        logic p;
        xact(dn, ra, 1'b1, 16'h0000, nb, 1'b0, 1'b0, r, p);
        chk("wire data", e, r);
        chk("wire parity", {15'h0000, dn != dv ? 1'b0 :
            par_of({dn, ra, 1'b1}, e, nb)}, {15'h0000, p});
    endtask : rd_chk

    task automatic wr_chk(input logic [2:0] dn, input logic [5:0] ra,
        input logic [15:0] wd, input logic bad, input logic cf,
        input logic eack);
        logic [15:0] r;
        logic p;
        xact(dn, ra, 1'b0, wd, 8, bad, cf, r, p);
        chk("wire ack", {15'h0000, eack}, {15'h0000, p});
    endtask : wr_chk

    task automatic part(input logic [15:0] v, input int n);
        int k;
        mdl_u.send_bit(swsb_pkg::BK_START);
        for (k = 15; k > 15 - n; k--) mdl_u.send_bit(kd(v[k]));
    endtask : part

    task automatic idle_chk(input logic [15:0] inc);
        mdl_u.go_idle(10);
        attn_exp = attn_exp + inc;
        chk("attn_go count", attn_exp, attn_cnt);
    endtask : idle_chk

    // =========================================
    // scenarios
    initial begin
        rst = 1'b1;
        sw_req = '0;
        app_rdata = 16'h0000;
        app_wide = 1'b0;
        void'($urandom(57));
        addr_strap = 1'($urandom);
        dv = addr_strap ? `DEVNUM_STRAP_HI : `DEVNUM_STRAP_LO;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (5) @(posedge clk_sys);
        sw_acc(1'b0, `SW_STAT, {5'h00, dv}, 8'hEF);
        sw_acc(1'b0, 4'h9, 8'h00, 8'hFF);
        mdl_u.bus_reset();
        rd_chk(dv, `REG_DEVNUM, 8, {13'h0000, dv});
        rd_chk(3'h3, `REG_DEVNUM, 8, 16'h0000);
        wr_chk(dv, `REG_CONTROL, 16'h0010, 1'b0, 1'b0, 1'b1);
        rd_chk(dv, `REG_CONTROL, 8, 16'h0010);
        wr_chk(`DEVNUM_BCAST, `REG_CONTROL, 16'h0030, 1'b0, 1'b0, 1'b1);
        rd_chk(dv, `REG_CONTROL, 8, 16'h0030);
        rnd = 16'($urandom);
        app_rdata <= rnd;
        app_wide <= 1'b1;
        app_exp.push_back(swsb_pkg::app_req_t'{rd: 1'b1, wr: 1'b0,
            addr: 6'h09, wdata: 16'h0000});
        rd_chk(dv, 6'h09, 16, rnd);
        app_wide <= 1'b0;
        rd_chk(`DEVNUM_BCAST, 6'h09, 8, 16'h0000);
        rnd = 16'($urandom);
        app_exp.push_back(swsb_pkg::app_req_t'{rd: 1'b0, wr: 1'b1,
            addr: 6'h0A, wdata: {8'h00, rnd[7:0]}});
        wr_chk(dv, 6'h0A, rnd, 1'b0, 1'b0, 1'b1);
        part({dv, `REG_CONTROL, 1'b1, 6'h00}, 3);
        rd_chk(dv, `REG_CONTROL, 8, 16'h0030);
        part({dv, `REG_CONTROL, 1'b0, 6'h15}, 13);
        rd_chk(dv, `REG_CONTROL, 8, 16'h0030);
        idle_chk(16'h0000);
        rd_chk(dv, `REG_STATUS, 8, 16'h0000);
        for (i = 0; i < 2; i++) begin
            wr_chk(dv, `REG_CONTROL, 16'h0000, i == 0, i == 1, 1'b0);
            idle_chk(16'h0001);
        end
        rd_chk(dv, `REG_CONTROL, 8, 16'h0030);
        rd_chk(dv, `REG_STATUS, 8, 16'h0080);
        rd_chk(dv, `REG_STATUS, 8, 16'h0000);
        mdl_u.bus_reset();
        sw_acc(1'b1, `SW_EVT, 8'h01, 8'h00);
        idle_chk(16'h0000);
        rd_chk(dv, `REG_CONTROL, 8, 16'h0030);
        sw_acc(1'b1, `SW_EVT, 8'h02, 8'h00);
        idle_chk(16'h0001);
        sw_acc(1'b1, `SW_EVT, 8'h01, 8'h00);
        idle_chk(16'h0000);
        rd_chk(dv, `REG_STATUS, 8, 16'h0003);
        sw_acc(1'b1, `SW_EVT, 8'h02, 8'h00);
        idle_chk(16'h0001);
        end_sim();
    end

    initial begin
        repeat (40000) @(posedge clk_sys);
        err_total++;
        end_sim();
    end
endmodule : tb_top
`default_nettype wire

// File: verification/wire_master_model.sv
// bus master and pulse-layer model facing the sensor bus slave
`timescale 1ns/1ps
`default_nettype none
module wire_master_model (
    input wire logic clk_sys,
    input wire logic tx_one,
    output swsb_pkg::bit_evt_t bit_evt,
    output logic bus_idle,
    output logic conflict
);
    initial begin
        bit_evt = '0;
        bus_idle = 1'b0;
        conflict = 1'b0;
    end

    // =========================================
    // bit signals
    // one decoded kind per pulse
    task automatic emit(input swsb_pkg::bit_kind_t k);
        bit_evt <= '{valid: 1'b1, kind: k};
        @(posedge clk_sys);
        bit_evt <= '0;
        repeat (5) @(posedge clk_sys);
    endtask : emit

    task automatic send_bit(input swsb_pkg::bit_kind_t k);
        @(posedge clk_sys);
        emit(k);
    endtask : send_bit

    task automatic slot(output logic b);
        @(posedge clk_sys);
        b = tx_one;
        emit(b ? swsb_pkg::BK_D1 : swsb_pkg::BK_D0);
    endtask : slot

    task automatic bus_reset();
        int i;
        send_bit(swsb_pkg::BK_RESET);
        for (i = 0; i < 8; i++) send_bit(swsb_pkg::BK_D0);
    endtask : bus_reset

    task automatic flag_conflict();
        @(posedge clk_sys);
        conflict <= 1'b1;
        @(posedge clk_sys);
        conflict <= 1'b0;
    endtask : flag_conflict

    task automatic go_idle(input int n);
        @(posedge clk_sys);
        bus_idle <= 1'b1;
        repeat (n) @(posedge clk_sys);
        bus_idle <= 1'b0;
    endtask : go_idle
endmodule : wire_master_model
`default_nettype wire
